// *** hw/kzt_pkg.sv ***
package kzt_pkg;
  // key store geometry
  localparam int          KEY_W    = 64;
  localparam int          GROUPS   = 8;
  localparam int          SLOTS    = 7;
  localparam int          LSLOTS   = GROUPS * SLOTS;
  localparam int          CHANS    = 64;
  localparam logic [5:0]  SLOTS6   = 6'h07;
  localparam logic [2:0]  NO_SLOT  = 3'h7;

  // timing
  localparam int          CLK_KHZ       = 200000;
  localparam int          FRAME_TIME_MS = 250;
  localparam int          HOLD_TIME_MS  = 1000;
  localparam int          FRAME_CYC_DEF = FRAME_TIME_MS * CLK_KHZ;
  localparam int          HOLD_CYC_DEF  = HOLD_TIME_MS * CLK_KHZ;
  localparam logic [1:0]  BOOT_CYC      = 2'h2;

  // register byte addresses
  localparam logic [7:0]  A_CONFIG  = 8'h00;
  localparam logic [7:0]  A_SELECT  = 8'h04;
  localparam logic [7:0]  A_KEY_LO  = 8'h08;
  localparam logic [7:0]  A_KEY_HI  = 8'h0c;
  localparam logic [7:0]  A_COMMAND = 8'h10;
  localparam logic [7:0]  A_LOCK    = 8'h14;
  localparam logic [7:0]  A_UNLOCK  = 8'h18;
  localparam logic [7:0]  A_CHAN    = 8'h1c;
  localparam logic [7:0]  A_STATUS  = 8'h20;

  // field positions
  localparam int CFG_EIGHT = 0;
  localparam int CFG_FED   = 1;
  localparam int CFG_KEYPD = 2;
  localparam int CMD_STORE = 0;
  localparam int CMD_XFER  = 1;
  localparam int CMD_SLAVE = 2;
  localparam int CH_INH    = 9;

  // synchronised pin indices
  localparam int P_ZERO = 0;
  localparam int P_ALL  = 1;
  localparam int P_EXE  = 2;
  localparam int P_TAMP = 3;
  localparam int P_DUMP = 4;
  localparam int P_SEP  = 5;
  localparam int P_SCRW = 6;
  localparam int P_UL   = 7;
  localparam int P_UR   = 8;
  localparam int NPIN   = 9;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_MASTER, MODE_SLAVE, MODE_LOCKED} mode_e;
endpackage

// *** hw/key_zeroize_tamper_control.sv ***
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Behaviour
// - zeroize held at power-on erases the whole loader store in any mode
// - execute button returns the loader from slave to master mode
// - master mode zeroize then all erases the seven slots of group one
// - in eight-group mode zeroize then all erases only the selected group
// - federal configuration limits the loader to one group of seven slots
// - lock code locks the loader; only the unlock code or a reset releases it
// - key fill into the radio is refused unless tamper switch is operated
// - any tamper release cuts key power and erases radio keys at once
// - keydump lets the current frame finish and starts no further frame
// - encrypted transmission runs in frames of about a quarter second
// - after keydump the radio stays non-functional until keys are reloaded
// - both upper keypad keys held one second flash message and erase keys
// - radio holds seven keys chosen by keypad or per-channel key number
// - sixty-four channels each with its own encryption inhibit
// - separation switch operation cuts keep-alive power, erasing radio keys
// - cover screw removal clears all seven stored radio keys
module key_zeroize_tamper_control
  import kzt_pkg::*;
#(
  parameter int          FRAME_CYC   = FRAME_CYC_DEF,
  parameter int          HOLD_CYC    = HOLD_CYC_DEF,
  parameter logic [31:0] LOCK_CODE   = 32'h00001111, // arbitrary preset
  parameter logic [31:0] UNLOCK_CODE = 32'h00002222  // arbitrary preset
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // buttons and switches, asynchronous
  input  wire logic        zeroize_button_i,
  input  wire logic        all_button_i,
  input  wire logic        execute_button_i,
  input  wire logic        tamper_switch_i,
  input  wire logic        keydump_i,
  input  wire logic        separation_switch_i,
  input  wire logic        cover_screw_removed_i,
  input  wire logic        keypad_upper_left_i,
  input  wire logic        keypad_upper_right_i,
  // transmitter, same clock
  input  wire logic        tx_request_i,
  output logic             tx_active_o,
  output logic             frame_start_o,
  // radio crypto state
  output logic             key_power_o,
  output logic             crypto_enable_o,
  output logic [2:0]       active_key_o,
  output logic             key_zero_msg_o,
  output logic [1:0]       mode_o
);

  typedef struct packed {
    logic [NPIN-1:0]               s1;
    logic [NPIN-1:0]               s2;
    logic [NPIN-1:0]               prev;
    logic [1:0]                    boot_cnt;
    logic                          booted;
    mode_e                         mode;
    logic                          zarm;
    logic [2:0]                    cfg;
    logic [2:0]                    grp;
    logic [2:0]                    slot;
    logic [2:0]                    kp_key;
    logic [5:0]                    chan;
    logic [31:0]                   key_lo;
    logic [31:0]                   key_hi;
    logic [LSLOTS-1:0][KEY_W-1:0]  lmem;
    logic [LSLOTS-1:0]             lval;
    logic [SLOTS-1:0][KEY_W-1:0]   rmem;
    logic [SLOTS-1:0]              rval;
    logic [CHANS-1:0][2:0]         ch_key;
    logic [CHANS-1:0]              ch_inh;
    logic                          dead;
    logic                          refused;
    logic                          zmsg;
    logic                          kpwr;
    logic                          cen;
    logic [2:0]                    akey;
    logic                          tx_on;
    logic                          tx_start;
    logic [27:0]                   tx_cnt;
    logic [27:0]                   hold_cnt;
    logic                          aw_got;
    logic                          w_got;
    logic [7:0]                    aw_addr;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
  } state_s;

  state_s q;
  state_s n;

  logic [NPIN-1:0] rise;
  logic            eight;
  logic [2:0]      egrp;
  logic [5:0]      lidx;
  logic            erase_all;
  logic            erase_grp;
  logic            radio_erase;
  logic            hold_fire;
  logic            do_wr;
  logic            unlock_ok;
  logic            store_ok;
  logic            xfer_ok;
  logic [2:0]      ksel;

  // byte-lane merge for read-write registers
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // handshake outputs straight from state; one write and one read in flight
  assign s_axi_awready   = !q.aw_got && !q.bvalid;
  assign s_axi_wready    = !q.w_got && !q.bvalid;
  assign s_axi_arready   = !q.rvalid;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rdata     = q.rdata;
  assign s_axi_rresp     = q.rresp;
  assign tx_active_o     = q.tx_on;
  assign frame_start_o   = q.tx_start;
  assign key_power_o     = q.kpwr;
  assign crypto_enable_o = q.cen;
  assign active_key_o    = q.akey;
  assign key_zero_msg_o  = q.zmsg;
  assign mode_o          = q.mode;

  // event decode from synchronised pins; all act on q so one cycle is coherent
  always_comb begin
    rise        = q.s2 & ~q.prev;
    eight       = q.cfg[CFG_EIGHT] && !q.cfg[CFG_FED];
    egrp        = eight ? q.grp : 3'h0;
    lidx        = egrp * SLOTS6 + {3'h0, q.slot};
    erase_all   = !q.booted && q.boot_cnt == BOOT_CYC && q.s2[P_ZERO];
    erase_grp   = q.booted && q.mode == MODE_MASTER && q.zarm && rise[P_ALL];
    hold_fire   = q.s2[P_UL] && q.s2[P_UR] && q.hold_cnt == 28'(HOLD_CYC - 1);
    // no width filter: one sampled release is enough to erase
    radio_erase = !q.s2[P_TAMP] || q.s2[P_DUMP] || q.s2[P_SEP] || q.s2[P_SCRW] || hold_fire;
    do_wr       = q.aw_got && q.w_got && !q.bvalid;
    unlock_ok   = do_wr && q.aw_addr == A_UNLOCK && q.w_data == UNLOCK_CODE && q.mode == MODE_LOCKED;
    // store commands are dropped, not delayed, when a loader erase falls in the same cycle; transfers also on a radio erase
    store_ok    = do_wr && q.aw_addr == A_COMMAND && q.w_data[CMD_STORE] && q.mode != MODE_LOCKED
                  && q.slot != NO_SLOT && !erase_all && !erase_grp;
    xfer_ok     = do_wr && q.aw_addr == A_COMMAND && q.w_data[CMD_XFER] && q.mode != MODE_LOCKED
                  && q.slot != NO_SLOT && q.lval[lidx] && q.s2[P_TAMP] && !radio_erase
                  && !erase_all && !erase_grp;
    ksel        = q.cfg[CFG_KEYPD] ? q.kp_key : q.ch_key[q.chan];
  end

  // next-state logic
  always_comb begin
    n          = q;
    n.s1       = {keypad_upper_right_i, keypad_upper_left_i, cover_screw_removed_i, separation_switch_i,
                  keydump_i, tamper_switch_i, execute_button_i, all_button_i, zeroize_button_i};
    n.s2       = q.s1;
    n.prev     = q.s2;
    n.tx_start = 1'b0;
    // power-on check waits for the synchroniser to fill
    if (!q.booted) begin
      n.boot_cnt = q.boot_cnt + 2'h1;
      n.booted   = q.boot_cnt == BOOT_CYC;
    end
    // operator buttons
    if (q.booted && rise[P_EXE] && q.mode == MODE_SLAVE) begin
      n.mode = MODE_MASTER;
      n.zarm = 1'b0;
    end else if (q.booted && q.mode == MODE_MASTER && rise[P_ZERO]) begin
      n.zarm = 1'b1;
    end else if (erase_grp) begin
      n.zarm = 1'b0;
    end
    // keypad hold counter saturates; the erase repeats while both keys stay held
    if (q.s2[P_UL] && q.s2[P_UR]) begin
      if (q.hold_cnt != 28'(HOLD_CYC - 1)) begin
        n.hold_cnt = q.hold_cnt + 28'h1;
      end
    end else begin
      n.hold_cnt = 28'h0;
    end
    // axi write capture
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got  = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
    end
    // axi write effects
    if (do_wr) begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      case (q.aw_addr)
        A_CONFIG: n.cfg = 3'(merge({29'h0, q.cfg}, q.w_data, q.w_strb));
        A_SELECT: {n.chan, n.kp_key, n.slot, n.grp} =
                    15'(merge({17'h0, q.chan, q.kp_key, q.slot, q.grp}, q.w_data, q.w_strb));
        A_KEY_LO: n.key_lo = merge(q.key_lo, q.w_data, q.w_strb);
        A_KEY_HI: n.key_hi = merge(q.key_hi, q.w_data, q.w_strb);
        A_COMMAND: begin
          n.refused = !(store_ok || xfer_ok) && q.w_data[CMD_XFER];
          if (store_ok) begin
            n.lmem[lidx] = {q.key_hi, q.key_lo};
            n.lval[lidx] = 1'b1;
          end
          if (xfer_ok) begin
            n.rmem[q.slot] = q.lmem[lidx]; // radio slot follows loader position
            n.rval[q.slot] = 1'b1;
            n.dead         = 1'b0;
            n.zmsg         = 1'b0;
          end
          if (q.w_data[CMD_SLAVE] && q.mode == MODE_MASTER) begin
            n.mode = MODE_SLAVE;
          end
        end
        A_LOCK: begin
          if (q.w_data == LOCK_CODE && q.mode != MODE_LOCKED) begin
            n.mode = MODE_LOCKED;
          end
        end
        A_UNLOCK: begin
          if (unlock_ok) begin
            n.mode = MODE_MASTER;
          end
        end
        A_CHAN: begin
          n.ch_key[q.w_data[5:0]] = q.w_data[8:6];
          n.ch_inh[q.w_data[5:0]] = q.w_data[CH_INH];
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // axi read
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        A_CONFIG: n.rdata = {29'h0, q.cfg};
        A_SELECT: n.rdata = {17'h0, q.chan, q.kp_key, q.slot, q.grp};
        A_KEY_LO: n.rdata = q.key_lo;
        A_KEY_HI: n.rdata = q.key_hi;
        A_STATUS: n.rdata = {17'h0, q.lval[lidx], q.s2[P_TAMP], q.rval, q.zmsg, q.refused,
                             q.tx_on, q.dead, q.mode};
        A_COMMAND, A_LOCK, A_UNLOCK, A_CHAN: n.rdata = 32'h0;
        default: begin
          n.rdata = 32'h0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    // loader erase overrides a same-cycle store; zeros and empty together
    if (erase_all) begin
      n.lmem = '0;
      n.lval = '0;
    end
    if (erase_grp) begin
      for (int s = 0; s < SLOTS; s++) begin
        n.lmem[int'(lidx) - int'(q.slot) + s] = '0;
        n.lval[int'(lidx) - int'(q.slot) + s] = 1'b0;
      end
    end
    // radio erase: any source kills keys and power in the same cycle
    n.kpwr = !radio_erase;
    if (radio_erase) begin
      n.rmem = '0;
      n.rval = '0;
      n.dead = 1'b1;
    end
    if (hold_fire) begin
      n.zmsg = 1'b1;
    end
    // registered crypto selection, seen one cycle after its inputs
    n.akey = ksel;
    n.cen  = ksel != NO_SLOT && q.rval[ksel] && !q.ch_inh[q.chan] && !q.dead;
    // frame timer: a started frame always runs out, even after keydump
    if (q.tx_on) begin
      n.tx_cnt = q.tx_cnt - 28'h1;
      if (q.tx_cnt == 28'h0) begin
        n.tx_on = 1'b0;
      end
    end else if (tx_request_i && q.cen && !q.dead) begin
      n.tx_on    = 1'b1;
      n.tx_start = 1'b1;
      n.tx_cnt   = 28'(FRAME_CYC - 1);
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q      <= '0;
      q.lmem <= q.lmem; // the loader store is battery held, so only zeroize clears it
      q.lval <= q.lval;
    end else begin
      q <= n;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_boot_zeroize: assert property (erase_all |=> q.lval == '0)
    else $error("power-on zeroize left loader keys");
  a_exe_master: assert property (q.booted && rise[P_EXE] && q.mode == MODE_SLAVE |=> q.mode == MODE_MASTER)
    else $error("execute did not return to master");
  a_fed_one_group: assert property (q.cfg[CFG_FED] && store_ok |=> q.lval[LSLOTS-1:SLOTS] == $past(q.lval[LSLOTS-1:SLOTS]))
    else $error("federal mode stored outside group one");
  a_lock_holds: assert property (q.mode == MODE_LOCKED && !unlock_ok |=> q.mode == MODE_LOCKED)
    else $error("locked state left without unlock code");
  a_fill_tamper: assert property (|(q.rval & ~$past(q.rval)) |-> $past(q.s2[P_TAMP], 1) && q.kpwr)
    else $error("key fill accepted with tamper released");
  a_tamper_erase: assert property (!q.s2[P_TAMP] |=> q.rval == '0 && !key_power_o && q.dead)
    else $error("tamper release did not erase keys");
  a_no_new_frame: assert property ($past(q.dead) |-> !frame_start_o)
    else $error("frame started after keydump");
  a_frame_runs: assert property (q.tx_on && q.tx_cnt != 28'h0 |=> q.tx_on)
    else $error("frame cut short");
  a_frame_min: assert property ($rose(q.tx_on) |-> q.tx_on [*8])
    else $error("frame shorter than eight cycles");
  a_group_only: assert property (erase_grp && eight && q.grp != 3'h0 |=> q.lval[SLOTS-1:0] == $past(q.lval[SLOTS-1:0]))
    else $error("group erase touched group one");

  c_frame: cover property ($rose(q.tx_on));
  c_locked: cover property (q.mode == MODE_LOCKED ##1 unlock_ok);
  c_xfer: cover property (xfer_ok);
  c_grp_erase: cover property (erase_grp);
endmodule

// *** verif/operator_panel.sv ***
`timescale 1ns/1ps
// operator buttons, radio switches and keypad as the far side sees them
module operator_panel
  import kzt_pkg::*;
(
  input  wire logic            clk_i,
  output logic [NPIN-1:0]      pin_o
);
  // the mounting plate holds the tamper switch operated from the start
  initial pin_o = 9'h008;

  // every change lands just after a rising edge
  task automatic set_pin(input int p, input logic v);
    @(posedge clk_i);
    pin_o[p] <= v;
  endtask

  // a press is held n cycles; the far side may be slow, so n is free
  task automatic press(input int p, input int n);
    set_pin(p, 1'b1);
    repeat (n) @(posedge clk_i);
    pin_o[p] <= 1'b0;
  endtask
endmodule

// *** verif/key_zeroize_tamper_control_bench.sv ***
`timescale 1ns/1ps
module key_zeroize_tamper_control_bench;
  import kzt_pkg::*;
  // short counts keep the run brief
  localparam int          FRAMES = 20;
  localparam int          HOLDS  = 10;
  localparam logic [31:0] LCODE  = 32'h00003c5a; // arbitrary preset
  localparam logic [31:0] UCODE  = 32'h0000a5c3; // arbitrary preset

  logic            clk_i, rstn_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, tx_req, tx_act, fstart, kpow, cen, kmsg;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata, seed, st;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp, mode, rsp;
  logic [2:0]      akey;
  logic [NPIN-1:0] pin;
  int              err_total, compares, cyc, fs_cnt, s, alen;

  key_zeroize_tamper_control #(.FRAME_CYC(FRAMES), .HOLD_CYC(HOLDS), .LOCK_CODE(LCODE), .UNLOCK_CODE(UCODE)) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .zeroize_button_i(pin[P_ZERO]), .all_button_i(pin[P_ALL]),
    .execute_button_i(pin[P_EXE]), .tamper_switch_i(pin[P_TAMP]), .keydump_i(pin[P_DUMP]),
    .separation_switch_i(pin[P_SEP]), .cover_screw_removed_i(pin[P_SCRW]),
    .keypad_upper_left_i(pin[P_UL]), .keypad_upper_right_i(pin[P_UR]), .tx_request_i(tx_req),
    .tx_active_o(tx_act), .frame_start_o(fstart), .key_power_o(kpow), .crypto_enable_o(cen),
    .active_key_o(akey), .key_zero_msg_o(kmsg), .mode_o(mode));

  operator_panel i_pad (.clk_i(clk_i), .pin_o(pin));

  // clock and a hang guard
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // frame starts counted where outputs have settled
  always @(negedge clk_i) if (fstart === 1'b1) fs_cnt++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // select word: group, loader slot, keypad key
  function automatic logic [31:0] sel(input int g, input int sl, input int kp);
    return {23'h0, kp[2:0], sl[2:0], g[2:0]};
  endfunction
  function automatic logic [31:0] chan(input logic inh, input int k);
    return {22'h0, inh, k[2:0], 6'h00};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // handshakes are judged at the negedge, where the values of the next rising edge already stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_i);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_i);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
  endtask
  task automatic stat();
    rd(A_STATUS, st, rsp);
  endtask
  task automatic store(input int g);
    wr(A_SELECT, sel(g, s, s), rsp);
    wr(A_KEY_LO, rnd(), rsp);
    wr(A_KEY_HI, rnd(), rsp);
    wr(A_COMMAND, 32'h1, rsp);
  endtask
  task automatic fill();
    store(0);
    wr(A_COMMAND, 32'h2, rsp);
  endtask
  task automatic zero_all();
    i_pad.press(P_ZERO, 4);
    wt(6);
    i_pad.press(P_ALL, 4);
    wt(6);
  endtask

  initial begin
    seed = 32'he9d7fc59;
    {rstn_i, awvalid, wvalid, bready, arvalid, rready, tx_req} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {err_total, compares, cyc, fs_cnt} = '0;
    i_pad.set_pin(P_ZERO, 1'b1); // a fresh loader store holds garbage until zeroized
    wt(2);
    rstn_i <= 1'b1;
    wt(8);
    i_pad.set_pin(P_ZERO, 1'b0);
    check("key power", kpow, 1'b1);
    wr(8'h40, 32'h0, rsp);
    check("bresp unmapped", rsp, RESP_SLVERR);
    rd(8'h44, st, rsp);
    check("rresp unmapped", rsp, RESP_SLVERR);
    // key choice by channel and by keypad, channel inhibit
    s = rnd() % 7;
    fill();
    stat();
    check("radio slot", st[6+s], 1'b1);
    wr(A_CHAN, chan(1'b0, s), rsp);
    wt(3);
    check("crypto chan", cen, 1'b1);
    check("active key", akey, s[2:0]);
    wr(A_CHAN, chan(1'b1, s), rsp);
    wt(3);
    check("crypto inhibit", cen, 1'b0);
    wr(A_CHAN, chan(1'b0, (s + 1) % 7), rsp);
    wr(A_CONFIG, 32'h4, rsp);
    wt(3);
    check("crypto keypad", cen, 1'b1);
    // keydump in mid frame: frame runs out, no next frame, radio stays dead
    fs_cnt = 0;
    tx_req <= 1'b1;
    while (fstart !== 1'b1) @(negedge clk_i);
    alen = 0;
    fork
      i_pad.press(P_DUMP, 3);
    join_none
    while (tx_act === 1'b1) begin
      alen++;
      @(negedge clk_i);
    end
    check("frame length", alen, FRAMES);
    wt(3 * FRAMES);
    check("frames started", fs_cnt, 1);
    check("crypto dead", cen, 1'b0);
    tx_req <= 1'b0;
    fill();
    wt(3);
    check("crypto reloaded", cen, 1'b1);
    // separation switch and cover screw each clear the radio keys
    for (int i = 0; i < 2; i++) begin
      fill();
      i_pad.press(i ? P_SCRW : P_SEP, 3);
      wt(6);
      stat();
      check("radio after switch", st[12:6], 7'h00);
    end
    // both keypad keys: short hold harmless, full hold erases with message
    fill();
    i_pad.set_pin(P_UL, 1'b1);
    i_pad.set_pin(P_UR, 1'b1);
    wt(HOLDS / 2);
    i_pad.set_pin(P_UL, 1'b0);
    i_pad.set_pin(P_UR, 1'b0);
    wt(6);
    check("msg short hold", kmsg, 1'b0);
    i_pad.set_pin(P_UL, 1'b1);
    i_pad.set_pin(P_UR, 1'b1);
    wt(HOLDS + 8);
    i_pad.set_pin(P_UL, 1'b0);
    i_pad.set_pin(P_UR, 1'b0);
    stat();
    check("key zero msg", kmsg, 1'b1);
    check("radio after hold", st[12:6], 7'h00);
    // tamper released: power cut, fill refused; a one-cycle glitch also erases
    fill();
    i_pad.set_pin(P_TAMP, 1'b0);
    wt(6);
    check("power tamper", kpow, 1'b0);
    wr(A_COMMAND, 32'h2, rsp);
    stat();
    check("fill refused", st[4], 1'b1);
    check("radio tamper", st[12:6], 7'h00);
    i_pad.set_pin(P_TAMP, 1'b1);
    wt(6);
    fill();
    i_pad.set_pin(P_TAMP, 1'b0);
    i_pad.set_pin(P_TAMP, 1'b1);
    wt(8);
    stat();
    check("radio glitch", st[12:6], 7'h00);
    // group erase: eight-group touches only the selected group
    wr(A_CONFIG, 32'h1, rsp);
    store(3);
    store(5);
    wr(A_SELECT, sel(3, s, s), rsp);
    zero_all();
    stat();
    check("group 3 erased", st[14], 1'b0);
    wr(A_SELECT, sel(5, s, s), rsp);
    stat();
    check("group 5 kept", st[14], 1'b1);
    // federal configuration folds a group 3 store into group one
    wr(A_CONFIG, 32'h3, rsp);
    store(3);
    wr(A_CONFIG, 32'h1, rsp);
    stat();
    check("federal group 3", st[14], 1'b0);
    wr(A_CONFIG, 32'h0, rsp);
    store(0);
    zero_all();
    stat();
    check("group 1 erased", st[14], 1'b0);
    wr(A_COMMAND, 32'h2, rsp);
    stat();
    check("empty fill refused", st[4], 1'b1);
    // lock codes and the execute button
    wr(A_LOCK, LCODE, rsp);
    wr(A_UNLOCK, LCODE, rsp);
    i_pad.press(P_EXE, 4);
    wt(6);
    check("mode locked", mode, MODE_LOCKED);
    store(0);
    stat();
    check("store locked", st[14], 1'b0);
    wr(A_UNLOCK, UCODE, rsp);
    check("mode unlocked", mode, MODE_MASTER);
    wr(A_COMMAND, 32'h4, rsp);
    check("mode slave", mode, MODE_SLAVE);
    i_pad.press(P_EXE, 4);
    wt(6);
    check("mode execute", mode, MODE_MASTER);
    // zeroize held through a restart from the locked mode
    store(0);
    wr(A_LOCK, LCODE, rsp);
    i_pad.set_pin(P_ZERO, 1'b1);
    rstn_i <= 1'b0;
    wt(3);
    rstn_i <= 1'b1;
    wt(8);
    i_pad.set_pin(P_ZERO, 1'b0);
    wr(A_SELECT, sel(0, s, s), rsp); // reset cleared the selection
    stat();
    check("power-on erase", st[14], 1'b0);
    complete_run();
  end
endmodule
